// [ptpr_defines.svh]
// Constants of the pulse terminal parameter register bank
`ifndef PTPR_DEFINES_SVH
`define PTPR_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define PTPR_ADDR_W        6
`define PTPR_IDX_CMD       6'h07
`define PTPR_IDX_DTYPE     6'h0d
`define PTPR_IDX_ALIGN     6'h0f
`define PTPR_IDX_MFR_FIRST 6'h10
`define PTPR_IDX_MFR_LAST  6'h1e
`define PTPR_IDX_UNLOCK    6'h1f
`define PTPR_IDX_FEATURE   6'h20
`define PTPR_IDX_SWON      6'h23
`define PTPR_IDX_USR_LAST  6'h2f
`define PTPR_USR_SWON_SLOT 4'h3

// ----------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------
`define PTPR_UNLOCK_CODE   16'h1235
`define PTPR_CMD_RESTORE   16'h7000
`define PTPR_DTYPE_VALUE   8'h04
`define PTPR_DT_NONE       8'h00
`define PTPR_DT_FIX_FIRST  8'h01
`define PTPR_DT_FIX_LAST   8'h08
`define PTPR_DT_VAR_FIRST  8'h11
`define PTPR_DT_VAR_LAST   8'h16
`define PTPR_FEATURE_RST   16'h0030
`define PTPR_HWREV_RST     16'h0003
`define PTPR_ZERO_WORD     16'h0000
`define PTPR_DEF_R36       16'hc350
`define PTPR_DEF_R38       16'h86a0
`define PTPR_DEF_R39       16'h0001
`define PTPR_DEF_R40       16'h03e8
`define PTPR_DEF_R41       16'h03e8
`define PTPR_DEF_R42       16'h0064
`define PTPR_DEF_R43       16'h0032
`define PTPR_MFR_SWON_RST  16'h0000

// ----------------------------------------------------------------
// Feature and control bit positions
// ----------------------------------------------------------------
`define PTPR_FB_WD_OFF     2
`define PTPR_FB_SIGNMAG    3
`define PTPR_FB_CNT_EDGE   4
`define PTPR_FB_RAMP       5
`define PTPR_FB_RAMP_UNIT  6
`define PTPR_FB_IN_DIRECT  7
`define PTPR_FB_WD_USER    8
`define PTPR_FB_TRAVEL     9
`define PTPR_FB_CNT_SET    10
`define PTPR_FB_MODE_HI    14
`define PTPR_FB_MODE_LO    13
`define PTPR_FB_NEG        15
`define PTPR_CTRL_CNT_CLR  5
`define PTPR_SIGN_BIT      15

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PTPR_WD_TIMEOUT_MS 100
`define PTPR_CLK_KHZ       200000
`define PTPR_WD_CYCLES     (`PTPR_WD_TIMEOUT_MS * `PTPR_CLK_KHZ)

`endif

// [ptpr_pkg.sv]
// Types of the pulse terminal parameter register bank
package ptpr_pkg;

  typedef logic [15:0] ptpr_word_t;

  typedef enum logic [1:0] {
    PTPR_MODE_FREQ     = 2'b00,
    PTPR_MODE_PULSEDIR = 2'b01,
    PTPR_MODE_ENCODER  = 2'b10,
    PTPR_MODE_RSVD     = 2'b11
  } ptpr_out_mode_t;

endpackage : ptpr_pkg

// [ptpr_watchdog.sv]
// Process data watchdog of the pulse terminal
`timescale 1ns/100ps
`include "ptpr_defines.svh"

module ptpr_watchdog #(
  parameter int unsigned WD_CYCLES = `PTPR_WD_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic kick,
  // Status
  output logic      expired
);

  logic [31:0] count;
  logic        at_limit;

  assign at_limit = (count >= WD_CYCLES - 32'h0000_0001);

  // Counts idle cycles since the last process data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
    end else if (kick || !enable) begin
      count <= 32'h0000_0000;
    end else if (!at_limit) begin
      count <= count + 32'h0000_0001;
    end
  end

  // Holds the overflow until fresh data arrives or the watchdog is disabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else if (kick || !enable) begin
      expired <= 1'b0;
    end else if (at_limit) begin
      expired <= 1'b1;
    end
  end

endmodule : ptpr_watchdog

// [ptpr_regs.sv]
// Parameter register bank of the pulse train output terminal
//
// Behaviour
// - Read-only data type code; 0x00 invalid, 0x01-0x08 fixed layouts.
// - Codes 0x11-0x16 repeat 0x01-0x06 with variable channel length.
// - Alignment bits are volatile, freely readable and writable.
// - Registers 16 to 30 hold manufacturer parameters, reloaded with defaults on reset.
// - Manufacturer area writes refused unless unlock word is held.
// - Registers 32 to 47 hold user parameters, write protected.
// - Writing 0x1235 unlocks; any other value locks again.
// - Unlock register reads its word when unlocked, zero when locked.
// - Register 16 reports the hardware revision.
// - Feature register resets to 0x0030 and selects operating modes.
// - Feature bit 2 clear runs watchdog; overflow outputs switch-on value.
// - Feature bit 3 selects sign-magnitude values, minus one is 0x8001.
// - Feature bit 4 clears counter on rising edge of control bit 5.
// - Feature bit 5 enables the frequency ramp.
// - Feature bit 6 selects ramp unit 10 or 1000 Hz/s.
// - Feature bit 8 picks manufacturer or user switch-on value.
// - Feature bit 9 enables travel distance control.
// - Command 0x7000 when unlocked restores user parameter defaults.
// - Watchdog overflows after 100 ms without process data.
`timescale 1ns/100ps
`include "ptpr_defines.svh"

module ptpr_regs #(
  parameter int unsigned WD_CYCLES = `PTPR_WD_CYCLES
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  // Register communication
  input  wire logic [5:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  output logic                        reg_rd_valid,
  output logic                        reg_wr_refused,
  // Process data
  input  wire logic                   pd_valid,
  input  wire logic [15:0]            pd_data,
  input  wire logic [7:0]             ctrl_byte,
  // Output value and counter control
  output logic      [15:0]            out_value,
  output logic                        wd_timeout,
  output logic                        counter_load,
  output logic                        counter_load_set,
  // Configuration for pulse generation
  output logic                        cfg_ramp_en,
  output logic                        cfg_ramp_unit_1000,
  output logic                        cfg_input_direct,
  output logic                        cfg_travel_en,
  output ptpr_pkg::ptpr_out_mode_t    cfg_out_mode,
  output logic                        cfg_neg_logic,
  output logic                        cfg_signmag,
  output logic                        params_unlocked
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] dtype_checked(input logic [7:0] code);
    logic fix_ok;
    logic var_ok;
    fix_ok = (code >= `PTPR_DT_FIX_FIRST) && (code <= `PTPR_DT_FIX_LAST);
    var_ok = (code >= `PTPR_DT_VAR_FIRST) && (code <= `PTPR_DT_VAR_LAST);
    // Codes outside both ranges report no valid type
    if (fix_ok) begin
      dtype_checked = code;
    end else if (var_ok) begin
      dtype_checked = code;
    end else begin
      dtype_checked = `PTPR_DT_NONE;
    end
  endfunction : dtype_checked

  function automatic logic [3:0] area_slot(input logic [5:0] addr,
                                           input logic [5:0] base);
    logic [5:0] diff;
    diff = addr - base;
    area_slot = diff[3:0];
  endfunction : area_slot

  function automatic logic [15:0] user_default(input logic [3:0] slot);
    logic [15:0] val;
    val = `PTPR_ZERO_WORD;
    unique case (slot)
      4'h0: val = `PTPR_FEATURE_RST;
      4'h4: val = `PTPR_DEF_R36;
      4'h6: val = `PTPR_DEF_R38;
      4'h7: val = `PTPR_DEF_R39;
      4'h8: val = `PTPR_DEF_R40;
      4'h9: val = `PTPR_DEF_R41;
      4'ha: val = `PTPR_DEF_R42;
      4'hb: val = `PTPR_DEF_R43;
      default: val = `PTPR_ZERO_WORD;
    endcase
    user_default = val;
  endfunction : user_default

  // Sign-magnitude to two's complement when selected
  function automatic logic [15:0] decode_value(input logic [15:0] raw,
                                               input logic signmag);
    logic [15:0] mag;
    mag = {1'b0, raw[14:0]};
    if (signmag && raw[`PTPR_SIGN_BIT]) begin
      decode_value = 16'h0000 - mag;
    end else begin
      decode_value = raw;
    end
  endfunction : decode_value

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] mfr_mem [0:14];
  logic [15:0] usr_mem [0:15];
  logic [15:0] align_bits;
  logic [15:0] unlock_word;
  logic [15:0] command_entry;
  logic [15:0] feature;
  logic        unlocked;
  logic        in_mfr;
  logic        in_usr;
  logic        wr_mfr;
  logic        wr_usr;
  logic        wr_refuse;
  logic        restore;
  logic [3:0]  mfr_slot;
  logic [3:0]  usr_slot;

  assign feature  = usr_mem[0];
  assign mfr_slot = area_slot(reg_addr, `PTPR_IDX_MFR_FIRST);
  assign usr_slot = area_slot(reg_addr, `PTPR_IDX_FEATURE);
  assign in_mfr   = (reg_addr >= `PTPR_IDX_MFR_FIRST) &&
                    (reg_addr <= `PTPR_IDX_MFR_LAST);
  assign in_usr   = (reg_addr >= `PTPR_IDX_FEATURE) &&
                    (reg_addr <= `PTPR_IDX_USR_LAST);
  assign wr_mfr   = reg_wr && in_mfr && unlocked;
  assign wr_usr   = reg_wr && in_usr && unlocked;
  assign wr_refuse = reg_wr && (in_mfr || in_usr) && !unlocked;
  assign restore  = reg_wr && (reg_addr == `PTPR_IDX_CMD) &&
                    (reg_wdata == `PTPR_CMD_RESTORE) && unlocked;

  // ----------------------------------------------------------------
  // Manufacturer area
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mfr_mem[0] <= `PTPR_HWREV_RST;
      for (int i = 1; i < 15; i++) begin
        mfr_mem[i] <= `PTPR_ZERO_WORD;
      end
    end else if (wr_mfr) begin
      mfr_mem[mfr_slot] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // User area, feature register in slot 0
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        usr_mem[i] <= user_default(4'(i));
      end
    end else if (restore) begin
      for (int i = 0; i < 16; i++) begin
        usr_mem[i] <= user_default(4'(i));
      end
    end else if (wr_usr) begin
      usr_mem[usr_slot] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Volatile registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      align_bits <= `PTPR_ZERO_WORD;
    end else if (reg_wr && (reg_addr == `PTPR_IDX_ALIGN)) begin
      align_bits <= reg_wdata;
    end
  end

  // Any write replaces the word; only the code word unlocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_word <= `PTPR_ZERO_WORD;
      unlocked    <= 1'b0;
    end else if (reg_wr && (reg_addr == `PTPR_IDX_UNLOCK)) begin
      unlock_word <= reg_wdata;
      unlocked    <= (reg_wdata == `PTPR_UNLOCK_CODE);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      command_entry <= `PTPR_ZERO_WORD;
    end else if (reg_wr && (reg_addr == `PTPR_IDX_CMD)) begin
      command_entry <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_refused <= 1'b0;
    end else begin
      reg_wr_refused <= wr_refuse;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = `PTPR_ZERO_WORD;
    if (in_mfr) begin
      rd_mux = mfr_mem[mfr_slot];
    end else if (in_usr) begin
      rd_mux = usr_mem[usr_slot];
    end else if (reg_addr == `PTPR_IDX_CMD) begin
      rd_mux = command_entry;
    end else if (reg_addr == `PTPR_IDX_DTYPE) begin
      rd_mux = {8'h00, dtype_checked(`PTPR_DTYPE_VALUE)};
    end else if (reg_addr == `PTPR_IDX_ALIGN) begin
      rd_mux = align_bits;
    end else if (reg_addr == `PTPR_IDX_UNLOCK) begin
      rd_mux = unlocked ? unlock_word : `PTPR_ZERO_WORD;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= `PTPR_ZERO_WORD;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic wd_expired;

  ptpr_watchdog #(
    .WD_CYCLES (WD_CYCLES)
  ) u_watchdog (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .enable  (!feature[`PTPR_FB_WD_OFF]),
    .kick    (pd_valid),
    .expired (wd_expired)
  );

  // ----------------------------------------------------------------
  // Output value
  // ----------------------------------------------------------------
  logic [15:0] swon_value;
  logic        wd_rise;
  logic        load_swon;

  assign swon_value = feature[`PTPR_FB_WD_USER] ?
                      usr_mem[`PTPR_USR_SWON_SLOT] :
                      `PTPR_MFR_SWON_RST;
  assign wd_rise    = wd_expired && !wd_timeout;

  // Switch-on value is applied once after reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_swon <= 1'b1;
    end else begin
      load_swon <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_timeout <= 1'b0;
    end else begin
      wd_timeout <= wd_expired;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_value <= `PTPR_MFR_SWON_RST;
    end else if (pd_valid) begin
      out_value <= decode_value(pd_data,
                                feature[`PTPR_FB_SIGNMAG]);
    end else if (load_swon || wd_rise) begin
      out_value <= swon_value;
    end
  end

  // ----------------------------------------------------------------
  // Counter clear on control edge
  // ----------------------------------------------------------------
  logic ctrl_clr_prev;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_clr_prev <= 1'b0;
    end else if (pd_valid) begin
      ctrl_clr_prev <= ctrl_byte[`PTPR_CTRL_CNT_CLR];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_load <= 1'b0;
    end else begin
      counter_load <= pd_valid && feature[`PTPR_FB_CNT_EDGE] &&
                      ctrl_byte[`PTPR_CTRL_CNT_CLR] &&
                      !ctrl_clr_prev;
    end
  end

  // ----------------------------------------------------------------
  // Feature configuration outputs
  // ----------------------------------------------------------------
  assign counter_load_set   = feature[`PTPR_FB_CNT_SET];
  assign cfg_input_direct   = feature[`PTPR_FB_IN_DIRECT];
  assign cfg_ramp_en        = feature[`PTPR_FB_RAMP];
  assign cfg_ramp_unit_1000 = feature[`PTPR_FB_RAMP_UNIT];
  assign cfg_travel_en      = feature[`PTPR_FB_TRAVEL];
  assign cfg_neg_logic      = feature[`PTPR_FB_NEG];
  assign cfg_signmag        = feature[`PTPR_FB_SIGNMAG];
  assign cfg_out_mode       = ptpr_pkg::ptpr_out_mode_t'(
    feature[`PTPR_FB_MODE_HI:`PTPR_FB_MODE_LO]);
  assign params_unlocked    = unlocked;

endmodule : ptpr_regs

// [ptpr_regs_chk.sv]
// Assertion checker of the parameter register bank
`timescale 1ns/100ps
`include "ptpr_defines.svh"

module ptpr_regs_chk #(
  parameter int unsigned WD_CYCLES = `PTPR_WD_CYCLES
) (
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     reset_n,
  // Register communication
  input wire logic [5:0]               reg_addr,
  input wire logic [15:0]              reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [15:0]              reg_rdata,
  input wire logic                     reg_wr_refused,
  // Process data and outputs
  input wire logic                     pd_valid,
  input wire logic [15:0]              pd_data,
  input wire logic [7:0]               ctrl_byte,
  input wire logic [15:0]              out_value,
  input wire logic                     wd_timeout,
  input wire logic                     counter_load,
  input wire logic                     cfg_ramp_en,
  input wire logic                     cfg_ramp_unit_1000,
  input wire ptpr_pkg::ptpr_out_mode_t cfg_out_mode,
  input wire logic                     cfg_signmag,
  input wire logic                     params_unlocked
);
  // ----------------------------------------------------------------
  // Cycles since last process data
  // ----------------------------------------------------------------
  logic [31:0] idle_cnt;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      idle_cnt <= 32'h0;
    else if (pd_valid)
      idle_cnt <= 32'h0;
    else
      idle_cnt <= idle_cnt + 32'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_dtype;
    reg_rd && reg_addr == `PTPR_IDX_DTYPE |=> reg_rdata == 16'h0004;
  endproperty
  a_dtype: assert property (p_dtype) else $error("dtype read wrong");

  property p_mfr_lock;
    reg_wr && !params_unlocked && reg_addr >= 6'h10 && reg_addr <= 6'h1e
      |=> reg_wr_refused;
  endproperty
  a_mfr_lock: assert property (p_mfr_lock) else $error("mfr write kept");

  property p_usr_lock;
    reg_wr && !params_unlocked && reg_addr >= 6'h20 && reg_addr <= 6'h2f
      |=> reg_wr_refused;
  endproperty
  a_usr_lock: assert property (p_usr_lock) else $error("usr write kept");

  property p_unlock;
    reg_wr && reg_addr == `PTPR_IDX_UNLOCK
      |=> params_unlocked == ($past(reg_wdata) == 16'h1235);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock state wrong");

  property p_unlock_rd;
    reg_rd && reg_addr == `PTPR_IDX_UNLOCK
      |=> reg_rdata == ($past(params_unlocked) ? 16'h1235 : 16'h0000);
  endproperty
  a_unlock_rd: assert property (p_unlock_rd) else $error("unlock read");

  property p_signmag;
    pd_valid && cfg_signmag && pd_data == 16'h8001 |=> out_value == 16'hffff;
  endproperty
  a_signmag: assert property (p_signmag) else $error("signmag wrong");

  property p_cnt_clr;
    counter_load |-> $past(pd_valid) && $past(ctrl_byte[5]);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("stray clear");

  property p_feature;
    reg_wr && params_unlocked && reg_addr == `PTPR_IDX_FEATURE
      |=> cfg_ramp_en == $past(reg_wdata[5])
          && cfg_ramp_unit_1000 == $past(reg_wdata[6])
          && cfg_out_mode == $past(reg_wdata[14:13]);
  endproperty
  a_feature: assert property (p_feature) else $error("feature bits");

  property p_restore;
    reg_wr && params_unlocked && reg_addr == `PTPR_IDX_CMD
      && reg_wdata == 16'h7000
      |=> cfg_ramp_en && !cfg_signmag && cfg_out_mode == 2'b00;
  endproperty
  a_restore: assert property (p_restore) else $error("restore failed");

  property p_wd;
    $rose(wd_timeout) |-> idle_cnt + 32'h2 >= WD_CYCLES
      && idle_cnt <= WD_CYCLES + 32'h4;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog delay");
endmodule : ptpr_regs_chk

bind ptpr_regs ptpr_regs_chk #(.WD_CYCLES(WD_CYCLES)) i_ptpr_regs_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_wr_refused(reg_wr_refused),
  .pd_valid(pd_valid), .pd_data(pd_data), .ctrl_byte(ctrl_byte),
  .out_value(out_value), .wd_timeout(wd_timeout),
  .counter_load(counter_load), .cfg_ramp_en(cfg_ramp_en),
  .cfg_ramp_unit_1000(cfg_ramp_unit_1000), .cfg_out_mode(cfg_out_mode),
  .cfg_signmag(cfg_signmag), .params_unlocked(params_unlocked));

// [ptpr_coupler_model.sv]
// Bus coupler model doing register communication
`timescale 1ns/100ps

module ptpr_coupler_model (
  // Clock
  input  wire logic        sys_clk,
  // Register communication
  output logic      [5:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rd_valid
);
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Idle lines show the inverse of the last value
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rd_valid ? reg_rdata : 16'hxxxx;
  endtask : rd

  task automatic unlock();
    wr(6'h1f, 16'h1235);
  endtask : unlock

  task automatic restore();
    wr(6'h07, 16'h7000);
  endtask : restore
endmodule : ptpr_coupler_model

// [pulse_terminal_param_regs_test.sv]
// Testbench of the parameter register bank
`timescale 1ns/100ps

module pulse_terminal_param_regs_test;
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] data;
    logic [15:0] exp;
  } ptpr_row_t;

  localparam int WD = 64;
  logic sys_clk = 1'b0, reset_n = 1'b0, pd_valid = 1'b0;
  logic [15:0] pd_data = 16'h0000, reg_wdata, reg_rdata, out_value, rv, w;
  logic [7:0] ctrl_byte = 8'h00;
  logic [5:0] reg_addr;
  logic reg_wr, reg_rd, reg_rd_valid, reg_wr_refused, wd_timeout;
  logic counter_load, counter_load_set, cfg_ramp_en, cfg_ramp_unit_1000;
  logic cfg_input_direct, cfg_travel_en, cfg_neg_logic, cfg_signmag;
  logic params_unlocked;
  ptpr_pkg::ptpr_out_mode_t cfg_out_mode;
  int error_cnt = 0, total_checks = 0, cyc = 0, n;
  ptpr_row_t rows [13] = '{
    '{1'b0, 6'h0d, 16'h0000, 16'h0004},
    '{1'b1, 6'h0d, 16'hffff, 16'h0004},
    '{1'b0, 6'h10, 16'h0000, 16'h0003},
    '{1'b1, 6'h10, 16'habcd, 16'h0003},
    '{1'b1, 6'h0f, 16'h00a5, 16'h00a5},
    '{1'b0, 6'h1f, 16'h0000, 16'h0000},
    '{1'b1, 6'h1f, 16'h1235, 16'h1235},
    '{1'b1, 6'h10, 16'h0007, 16'h0007},
    '{1'b1, 6'h1e, 16'h5a5a, 16'h5a5a},
    '{1'b1, 6'h2f, 16'h1234, 16'h1234},
    '{1'b1, 6'h1f, 16'h1111, 16'h0000},
    '{1'b1, 6'h24, 16'h9999, 16'hc350},
    '{1'b0, 6'h3f, 16'h0000, 16'h0000}};

  always #2.5 sys_clk = ~sys_clk;

  ptpr_regs #(.WD_CYCLES(WD)) i_ptpr_regs (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .reg_wr_refused(reg_wr_refused), .pd_valid(pd_valid),
    .pd_data(pd_data), .ctrl_byte(ctrl_byte), .out_value(out_value),
    .wd_timeout(wd_timeout), .counter_load(counter_load),
    .counter_load_set(counter_load_set), .cfg_ramp_en(cfg_ramp_en),
    .cfg_ramp_unit_1000(cfg_ramp_unit_1000),
    .cfg_input_direct(cfg_input_direct), .cfg_travel_en(cfg_travel_en),
    .cfg_out_mode(cfg_out_mode), .cfg_neg_logic(cfg_neg_logic),
    .cfg_signmag(cfg_signmag), .params_unlocked(params_unlocked));

  ptpr_coupler_model i_ptpr_coupler_model (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [15:0] got,
                       input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic pd(input logic [15:0] d, input logic [7:0] c);
    @(posedge sys_clk);
    pd_valid <= 1'b1;
    pd_data <= d;
    ctrl_byte <= c;
    @(posedge sys_clk);
    pd_valid <= 1'b0;
    #1;
  endtask : pd

  function automatic logic [15:0] cfg_of(input logic [15:0] f);
    return {7'h00, f[15], f[14:13], f[10], f[9], f[7], f[6], f[5], f[3]};
  endfunction : cfg_of

  function automatic logic [15:0] cfg_seen();
    return {7'h00, cfg_neg_logic, cfg_out_mode, counter_load_set,
            cfg_travel_en, cfg_input_direct, cfg_ramp_unit_1000,
            cfg_ramp_en, cfg_signmag};
  endfunction : cfg_seen

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      if (rows[i].wr)
        i_ptpr_coupler_model.wr(rows[i].addr, rows[i].data);
      i_ptpr_coupler_model.rd(rows[i].addr, rv);
      check("row read", rv, rows[i].exp);
    end
    i_ptpr_coupler_model.wr(6'h2f, 16'h0001);
    #1;
    check("refused", {15'h0, reg_wr_refused}, 16'h0001);
    check("locked", {15'h0, params_unlocked}, 16'h0000);
    i_ptpr_coupler_model.unlock();
    #1;
    check("unlocked", {15'h0, params_unlocked}, 16'h0001);
    i_ptpr_coupler_model.wr(6'h20, 16'h0018);
    pd(16'h8001, 8'h00);
    check("signmag", out_value, 16'hffff);
    pd(16'h0000, 8'h20);
    check("clear edge", {15'h0, counter_load}, 16'h0001);
    pd(16'h0000, 8'h20);
    check("clear level", {15'h0, counter_load}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      w = {1'b0, i[1:0], 13'h0} | ((i == 1) ? 16'h84c0 : 16'h0220);
      i_ptpr_coupler_model.wr(6'h20, w);
      #1;
      check("modes", cfg_seen(), cfg_of(w));
    end
    i_ptpr_coupler_model.restore();
    i_ptpr_coupler_model.rd(6'h2f, rv);
    check("restore 47", rv, 16'h0000);
    i_ptpr_coupler_model.rd(6'h20, rv);
    check("restore 32", rv, 16'h0030);
    i_ptpr_coupler_model.wr(6'h23, 16'h0042);
    i_ptpr_coupler_model.wr(6'h20, 16'h0130);
    pd(16'h0005, 8'h00);
    check("pd value", out_value, 16'h0005);
    n = 0;
    while (wd_timeout !== 1'b1 && n < 3 * WD) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("wd value", out_value, 16'h0042);
    check("wd late", {15'h0, n > WD - 8}, 16'h0001);
    pd(16'h0007, 8'h00);
    @(posedge sys_clk);
    #1;
    check("wd kick", {15'h0, wd_timeout}, 16'h0000);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("reset cfg", cfg_seen(), cfg_of(16'h0030));
    check("reset out", out_value, 16'h0000);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    i_ptpr_coupler_model.rd(6'h20, rv);
    check("reset feature", rv, 16'h0030);
    i_ptpr_coupler_model.rd(6'h1f, rv);
    check("reset lock", rv, 16'h0000);
    summarize();
  end
endmodule : pulse_terminal_param_regs_test
